// [verilog/isp_input_sync_params.sv]
// Purpose: input sync parameter bank, input sampling trigger and cycle diagnostics
// Assumes: strobes and events are one-cycle pulses synchronous to clk_sys_i
// Notes:   timing entries count in steps of one clock period in ns
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "isp_params.svh"

// Notes on behaviour
// - mode selects free run, SYNC0, SYNC1, SM2
// - mode 1 uses SM3, only without outputs
// - report SYNC0 to sampling delay in ns
// - report sampling to master availability in ns
// - report maximum SYNC1 to sampling delay
// - supported bitmap: free, SM, DC 01
// - bits 4-5: 01 local, 10 SYNC1
// - bit 14 flags command-driven dynamic measurement
// - entry 0 reads constant 0x20
// - command 1 starts and resets, 0 stops
// - cycle period defaults to 1000000 ns
// - fixed minimum cycle time 100000 ns
// - count missed events, overruns, short shifts
module isp_input_sync_params (
	input  wire logic              clk_sys_i,
	input  wire logic              arst_n_i,
	input  wire logic [7:0]        addr_i,
	input  wire logic [31:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [31:0]       rdata_o,
	input  wire isp_pkg::isp_evt_s evt_i,
	input  wire logic              has_outputs_i,
	input  wire logic              operational_i,
	input  wire logic              copy_done_i,
	output logic                   sample_o,
	output logic                   ready_o,
	output logic                   irq_o
);
	isp_pkg::isp_req_s   req;
	isp_pkg::isp_state_e state_q, state_d;
	logic [15:0] mode_q, mode_d, cmd_q, cmd_d, support_q, support_d;
	logic [31:0] period_q, period_d, shift_q, shift_d, copy_q, copy_d;
	logic [31:0] maxdly_q, maxdly_d, t0_q, t0_d, t1_q, t1_d, tc_q, tc_d;
	logic [31:0] timer_q, timer_d, rdata_d;
	logic [15:0] missed_q, missed_d, over_q, over_d, short_q, short_d;
	logic        fault_q, fault_d, sm_seen_q, sm_seen_d, strap_q, strap_d;
	logic [`ISP_IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic        sample_d, ready_d, irq_d, trig, dc_mode, tick;
	logic [31:0] per_cyc, dly0, dly1;

	// bundle the register port
	assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

	// free-run period in clock cycles, at least one
	assign per_cyc = (period_q < `ISP_CLK_NS) ? 32'h00000001 : period_q / `ISP_CLK_NS;
	assign tick    = (timer_q >= per_cyc - 32'h00000001);
	assign dc_mode = (mode_q == `ISP_MODE_SYNC0) || (mode_q == `ISP_MODE_SYNC1);

	// delay since the last sync event, zero when the event falls on this edge
	assign dly0    = evt_i.sync0 ? 32'h00000000 : t0_q;
	assign dly1    = evt_i.sync1 ? 32'h00000000 : t1_q;

	// trigger source selected by the mode entry
	always_comb begin
		case (mode_q)
			`ISP_MODE_FREE:  trig = tick;
			`ISP_MODE_SM3:   trig = evt_i.sm3;
			`ISP_MODE_SYNC0: trig = evt_i.sync0;
			`ISP_MODE_SYNC1: trig = evt_i.sync1;
			`ISP_MODE_SM2:   trig = evt_i.sm2;
			default:         trig = 1'b0;
		endcase
	end

	// next values of registers, timers, counters and outputs
	always_comb begin
		state_d   = state_q;
		mode_d    = mode_q;
		cmd_d     = cmd_q;
		period_d  = period_q;
		shift_d   = shift_q;
		copy_d    = copy_q;
		maxdly_d  = maxdly_q;
		missed_d  = missed_q;
		over_d    = over_q;
		short_d   = short_q;
		fault_d   = fault_q;
		mask_d    = mask_q;
		strap_d   = 1'b1;
		support_d = support_q;
		sample_d  = 1'b0;
		ready_d   = 1'b0;
		ev        = '0;
		rdata_d   = '0;
		timer_d   = (mode_q != `ISP_MODE_FREE || tick) ? 32'h00000000 : timer_q + 32'h00000001;
		t0_d      = evt_i.sync0 ? `ISP_CLK_NS : t0_q + `ISP_CLK_NS;
		t1_d      = evt_i.sync1 ? `ISP_CLK_NS : t1_q + `ISP_CLK_NS;
		tc_d      = tc_q + `ISP_CLK_NS;
		// an SM2 or SM3 event since the last SYNC0 marks the cycle as served; set wins
		sm_seen_d = (evt_i.sm2 || evt_i.sm3) ? 1'b1 : (evt_i.sync0 ? 1'b0 : sm_seen_q);

		// bitmap caught once after reset release from the outputs strap
		if (!strap_q) begin
			support_d = `ISP_SUP_BASE | `ISP_SUP_DYNAMIC
			          | (has_outputs_i ? `ISP_SUP_LOCAL : `ISP_SUP_SYNC1);
		end

		// sampling sequence
		case (state_q)
			isp_pkg::ISP_IDLE: begin
				if (trig) begin
					sample_d = 1'b1;
					state_d  = isp_pkg::ISP_COPY;
					tc_d     = `ISP_CLK_NS;
					if (dc_mode && cmd_q[0] && dly0 > shift_q) begin
						shift_d = dly0;
					end
					if (mode_q == `ISP_MODE_SYNC1 && cmd_q[0] && dly1 > maxdly_q) begin
						maxdly_d = dly1;
					end
					if (dc_mode) begin
						fault_d = 1'b0;
					end
				end
			end
			isp_pkg::ISP_COPY: begin
				if (copy_done_i) begin
					ready_d = 1'b1;
					state_d = isp_pkg::ISP_IDLE;
					if (dc_mode && cmd_q[0] && tc_q > copy_q) begin
						copy_d = tc_q;
					end
				end
				if (trig) begin
					ev[`ISP_IRQ_OVERRUN] = operational_i;
					if (dc_mode) begin
						fault_d             = 1'b1;
						ev[`ISP_IRQ_FAULT] = 1'b1;
					end
				end
			end
			default: state_d = isp_pkg::ISP_IDLE;
		endcase

		// diagnostics while operational
		if (operational_i && dc_mode && evt_i.sync0 && !sm_seen_q) begin
			ev[`ISP_IRQ_MISSED] = 1'b1;
		end
		if (operational_i && dc_mode && evt_i.sync1 && state_q == isp_pkg::ISP_COPY) begin
			ev[`ISP_IRQ_SHORT] = 1'b1;
		end
		if (ev[`ISP_IRQ_OVERRUN] && over_q != `ISP_CNT_MAX) begin
			over_d = over_q + 16'h0001;
		end
		if (ev[`ISP_IRQ_MISSED] && missed_q != `ISP_CNT_MAX) begin
			missed_d = missed_q + 16'h0001;
		end
		if (ev[`ISP_IRQ_SHORT] && short_q != `ISP_CNT_MAX) begin
			short_d = short_q + 16'h0001;
		end

		// register writes
		if (req.wr) begin
			if (req.addr == `ISP_IDX_MODE) begin
				if (req.wdata[15:0] == `ISP_MODE_FREE || req.wdata[15:0] == `ISP_MODE_SYNC0
				    || req.wdata[15:0] == `ISP_MODE_SYNC1 || req.wdata[15:0] == `ISP_MODE_SM2
				    || (req.wdata[15:0] == `ISP_MODE_SM3 && !has_outputs_i)) begin
					mode_d = req.wdata[15:0];
				end
			end else if (req.addr == `ISP_IDX_PERIOD) begin
				period_d = req.wdata;
			end else if (req.addr == `ISP_IDX_CMD) begin
				cmd_d = req.wdata[15:0];
				if (req.wdata[0]) begin
					shift_d  = 32'h00000000;
					copy_d   = 32'h00000000;
					maxdly_d = 32'h00000000;
				end
			end else if (req.addr == `ISP_IDX_IRQ_MASK) begin
				mask_d = req.wdata[`ISP_IRQ_W-1:0];
			end
		end
		// write one to clear, a new event wins
		stat_d = stat_q & ~((req.wr && req.addr == `ISP_IDX_IRQ_STAT) ?
		                    req.wdata[`ISP_IRQ_W-1:0] : {`ISP_IRQ_W{1'b0}});
		stat_d = stat_d | ev;
		irq_d  = |(stat_d & mask_d);

		// register reads, answered one cycle later
		if (req.rd) begin
			if (req.addr == `ISP_IDX_COUNT) begin
				rdata_d = {24'h000000, `ISP_ENTRY_COUNT};
			end else if (req.addr == `ISP_IDX_MODE) begin
				rdata_d = {16'h0000, mode_q};
			end else if (req.addr == `ISP_IDX_PERIOD) begin
				rdata_d = period_q;
			end else if (req.addr == `ISP_IDX_SHIFT) begin
				rdata_d = shift_q;
			end else if (req.addr == `ISP_IDX_SUPPORT) begin
				rdata_d = {16'h0000, support_q};
			end else if (req.addr == `ISP_IDX_MINPER) begin
				rdata_d = `ISP_MIN_PERIOD;
			end else if (req.addr == `ISP_IDX_COPY) begin
				rdata_d = copy_q;
			end else if (req.addr == `ISP_IDX_MINDLY) begin
				rdata_d = `ISP_MIN_DELAY;
			end else if (req.addr == `ISP_IDX_CMD) begin
				rdata_d = {16'h0000, cmd_q};
			end else if (req.addr == `ISP_IDX_MAXDLY) begin
				rdata_d = maxdly_q;
			end else if (req.addr == `ISP_IDX_MISSED) begin
				rdata_d = {16'h0000, missed_q};
			end else if (req.addr == `ISP_IDX_OVERRUN) begin
				rdata_d = {16'h0000, over_q};
			end else if (req.addr == `ISP_IDX_SHORT) begin
				rdata_d = {16'h0000, short_q};
			end else if (req.addr == `ISP_IDX_FAULT) begin
				rdata_d = {31'h00000000, fault_q};
			end else if (req.addr == `ISP_IDX_IRQ_STAT) begin
				rdata_d = {28'h0000000, stat_q};
			end else if (req.addr == `ISP_IDX_IRQ_MASK) begin
				rdata_d = {28'h0000000, mask_q};
			end
		end
	end

	// state registers
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q   <= isp_pkg::ISP_IDLE;
			mode_q    <= `ISP_MODE_RST;
			cmd_q     <= 16'h0000;
			period_q  <= `ISP_PERIOD_RST;
			support_q <= `ISP_SUPPORT_RST;
			strap_q   <= 1'b0;
			shift_q   <= 32'h00000000;
			copy_q    <= 32'h00000000;
			maxdly_q  <= 32'h00000000;
			t0_q      <= 32'h00000000;
			t1_q      <= 32'h00000000;
			tc_q      <= 32'h00000000;
			timer_q   <= 32'h00000000;
			missed_q  <= 16'h0000;
			over_q    <= 16'h0000;
			short_q   <= 16'h0000;
			fault_q   <= 1'b0;
			sm_seen_q <= 1'b0;
			stat_q    <= '0;
			mask_q    <= '0;
			rdata_o   <= 32'h00000000;
			sample_o  <= 1'b0;
			ready_o   <= 1'b0;
			irq_o     <= 1'b0;
		end else begin
			state_q   <= state_d;
			mode_q    <= mode_d;
			cmd_q     <= cmd_d;
			period_q  <= period_d;
			support_q <= support_d;
			strap_q   <= strap_d;
			shift_q   <= shift_d;
			copy_q    <= copy_d;
			maxdly_q  <= maxdly_d;
			t0_q      <= t0_d;
			t1_q      <= t1_d;
			tc_q      <= tc_d;
			timer_q   <= timer_d;
			missed_q  <= missed_d;
			over_q    <= over_d;
			short_q   <= short_d;
			fault_q   <= fault_d;
			sm_seen_q <= sm_seen_d;
			stat_q    <= stat_d;
			mask_q    <= mask_d;
			rdata_o   <= rdata_d;
			sample_o  <= sample_d;
			ready_o   <= ready_d;
			irq_o     <= irq_d;
		end
	end

	// checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_sm2_trig;
		mode_q == `ISP_MODE_SM2 && evt_i.sm2 && state_q == isp_pkg::ISP_IDLE;
	endsequence
	sequence s_copy_end;
		state_q == isp_pkg::ISP_COPY && copy_done_i;
	endsequence

	chk_sm2_sample_pulse: assert property (s_sm2_trig |=> sample_o ##1 !sample_o)
		else $error("sample pulse missing after SM2 event");
	chk_sm3_mode_guard: assert property (
		wr_i && addr_i == `ISP_IDX_MODE && wdata_i[15:0] == `ISP_MODE_SM3 && has_outputs_i
		|=> $stable(mode_q))
		else $error("SM3 mode taken although outputs exist");
	chk_copy_ready: assert property (s_copy_end |=> ready_o && state_q == isp_pkg::ISP_IDLE)
		else $error("ready pulse missing after copy end");
	chk_count_read: assert property (
		rd_i && addr_i == `ISP_IDX_COUNT |=> rdata_o == {24'h000000, `ISP_ENTRY_COUNT})
		else $error("entry count reads wrong");
	chk_minper_read: assert property (rd_i && addr_i == `ISP_IDX_MINPER |=> rdata_o == `ISP_MIN_PERIOD)
		else $error("minimum period reads wrong");
	chk_cmd_clears: assert property (
		wr_i && addr_i == `ISP_IDX_CMD && wdata_i[0] |=> shift_q == 32'h00000000 && copy_q == 32'h00000000)
		else $error("measurement not reset on start");
	chk_overrun_count: assert property (
		operational_i && trig && state_q == isp_pkg::ISP_COPY && over_q != `ISP_CNT_MAX
		|=> over_q == $past(over_q) + 16'h0001)
		else $error("overrun not counted");
	chk_support_bits: assert property ($past(strap_q) |-> support_q[5:4] ==
		($past(has_outputs_i, 2) ? 2'b01 : 2'b10) || $past(strap_q, 2))
		else $error("supported bitmap shift field wrong");
	chk_irq_level: assert property (##1 irq_o == |$past(stat_d & mask_d))
		else $error("interrupt level disagrees with status and mask");

	// each timed mode samples on its own event
	chk_sync0_sample: assert property (
		mode_q == `ISP_MODE_SYNC0 && evt_i.sync0 && state_q == isp_pkg::ISP_IDLE |=> sample_o)
		else $error("sample pulse missing after SYNC0 event");
	chk_sync1_sample: assert property (
		mode_q == `ISP_MODE_SYNC1 && evt_i.sync1 && state_q == isp_pkg::ISP_IDLE |=> sample_o)
		else $error("sample pulse missing after SYNC1 event");
	chk_free_sample: assert property (
		mode_q == `ISP_MODE_FREE && tick && state_q == isp_pkg::ISP_IDLE |=> sample_o)
		else $error("sample pulse missing on free-run tick");
	chk_sm3_sample: assert property (
		mode_q == `ISP_MODE_SM3 && evt_i.sm3 && state_q == isp_pkg::ISP_IDLE |=> sample_o)
		else $error("sample pulse missing after SM3 event");
	chk_mode_write: assert property (
		wr_i && addr_i == `ISP_IDX_MODE && wdata_i[15:0] == `ISP_MODE_SYNC0
		|=> mode_q == `ISP_MODE_SYNC0)
		else $error("valid mode write not taken");

	// measurement keeps the largest delay while running, holds when stopped
	sequence s_take_idle;
		state_q == isp_pkg::ISP_IDLE && trig && !(wr_i && addr_i == `ISP_IDX_CMD);
	endsequence
	sequence s_dc_take;
		s_take_idle ##0 (dc_mode && cmd_q[0]);
	endsequence
	chk_shift_track: assert property (s_dc_take |=> shift_q >= $past(dly0))
		else $error("shift time below measured delay");
	chk_maxdly_track: assert property (
		s_dc_take ##0 mode_q == `ISP_MODE_SYNC1 |=> maxdly_q >= $past(dly1))
		else $error("maximum delay below measured delay");
	chk_copy_track: assert property (
		s_copy_end ##0 (dc_mode && cmd_q[0] && !(wr_i && addr_i == `ISP_IDX_CMD))
		|=> copy_q >= $past(tc_q))
		else $error("copy latency below measured time");
	chk_cmd_stop: assert property (s_take_idle ##0 !cmd_q[0] |=> $stable(shift_q))
		else $error("shift time changed while measurement stopped");

	// bitmap fields once the strap has been caught
	chk_support_base: assert property (
		strap_q |-> (support_q & ~(`ISP_SUP_LOCAL | `ISP_SUP_SYNC1))
		            == (`ISP_SUP_BASE | `ISP_SUP_DYNAMIC))
		else $error("supported bitmap base fields wrong");
	chk_period_write: assert property (
		wr_i && addr_i == `ISP_IDX_PERIOD |=> period_q == $past(wdata_i))
		else $error("cycle period write not taken");

	// diagnostic counters while operational, sync fault flag and status bits
	chk_missed_count: assert property (
		operational_i && dc_mode && evt_i.sync0 && !sm_seen_q && missed_q != `ISP_CNT_MAX
		|=> missed_q == $past(missed_q) + 16'h0001)
		else $error("missed event not counted");
	chk_short_count: assert property (
		operational_i && dc_mode && evt_i.sync1 && state_q == isp_pkg::ISP_COPY
		&& short_q != `ISP_CNT_MAX |=> short_q == $past(short_q) + 16'h0001)
		else $error("short shift not counted");
	chk_fault_set: assert property (
		dc_mode && trig && state_q == isp_pkg::ISP_COPY |=> fault_q)
		else $error("sync fault not raised on late cycle");
	chk_status_set: assert property (|ev |=> (stat_q & $past(ev)) == $past(ev))
		else $error("status bit lost against its event");
endmodule // isp_input_sync_params

// [pkg/isp_params.svh]
// Purpose: constants for the input sync parameter register bank
// Assumes: 100 MHz system clock, word index addressing on the register port
// Notes:   offsets are entry indices; the read data bus is 32 bits wide
`ifndef ISP_PARAMS_SVH
`define ISP_PARAMS_SVH
// entry indices
`define ISP_IDX_COUNT    8'h00
`define ISP_IDX_MODE     8'h01
`define ISP_IDX_PERIOD   8'h02
`define ISP_IDX_SHIFT    8'h03
`define ISP_IDX_SUPPORT  8'h04
`define ISP_IDX_MINPER   8'h05
`define ISP_IDX_COPY     8'h06
`define ISP_IDX_MINDLY   8'h07
`define ISP_IDX_CMD      8'h08
`define ISP_IDX_MAXDLY   8'h09
`define ISP_IDX_MISSED   8'h0B
`define ISP_IDX_OVERRUN  8'h0C
`define ISP_IDX_SHORT    8'h0D
`define ISP_IDX_FAULT    8'h20
`define ISP_IDX_IRQ_STAT 8'h30
`define ISP_IDX_IRQ_MASK 8'h31
// reset and constant values
`define ISP_ENTRY_COUNT  8'h20
`define ISP_MODE_RST     16'h0022
`define ISP_PERIOD_RST   32'h000F4240
`define ISP_SUPPORT_RST  16'h0002
`define ISP_MIN_PERIOD   32'h000186A0
`define ISP_MIN_DELAY    32'h00000000
// mode codes
`define ISP_MODE_FREE    16'h0000
`define ISP_MODE_SM3     16'h0001
`define ISP_MODE_SYNC0   16'h0002
`define ISP_MODE_SYNC1   16'h0003
`define ISP_MODE_SM2     16'h0022
// supported-modes fields
`define ISP_SUP_BASE     16'h0007
`define ISP_SUP_LOCAL    16'h0010
`define ISP_SUP_SYNC1    16'h0020
`define ISP_SUP_DYNAMIC  16'h4000
// timing
`define ISP_CLK_NS       32'h0000000A
`define ISP_CNT_MAX      16'hFFFF
// interrupt status bits
`define ISP_IRQ_W        4
`define ISP_IRQ_OVERRUN  0
`define ISP_IRQ_MISSED   1
`define ISP_IRQ_SHORT    2
`define ISP_IRQ_FAULT    3
`endif

// [pkg/isp_pkg.sv]
// Purpose: types for the input sync parameter register bank
// Assumes: constants live in isp_params.svh
// Notes:   events arrive as one-cycle pulses grouped in one struct
package isp_pkg;
	typedef struct packed {
		logic sm2;
		logic sm3;
		logic sync0;
		logic sync1;
	} isp_evt_s;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} isp_req_s;

	typedef enum logic [0:0] {
		ISP_IDLE = 1'b0,
		ISP_COPY = 1'b1
	} isp_state_e;
endpackage

// [verification/isp_master_model.sv]
// Purpose: bus master and application stand-in for the input sync bank
// Assumes: fire_i is a one-cycle request from the bench
// Notes:   copy_dly_i of 0 never answers, which leaves a copy hanging
`timescale 1ns/1ps
module isp_master_model (
	input  wire logic              clk_sys_i,
	input  wire logic              arst_n_i,
	input  wire isp_pkg::isp_evt_s fire_i,
	input  wire logic              sample_i,
	input  wire logic [7:0]        copy_dly_i,
	output isp_pkg::isp_evt_s      evt_o,
	output logic                   copy_done_o
);
	logic [7:0] cnt_q;

	// event pulses one cycle after the request, copy answer after a delay
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			evt_o       <= '0;
			cnt_q       <= 8'h00;
			copy_done_o <= 1'b0;
		end else begin
			evt_o       <= fire_i; // one pulse per request
			copy_done_o <= (cnt_q == 8'h01); // answer only after a sample
			if (sample_i)
				cnt_q <= copy_dly_i;
			else if (cnt_q != 8'h00)
				cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule // isp_master_model

// [verification/input_sync_parameters_tb_top.sv]
// Purpose: self-checking bench for the input sync parameter bank
// Assumes: one 100 MHz clock, reset held 12 cycles
// Notes:   each scenario starts from a fresh reset
`timescale 1ns/1ps
`include "isp_params.svh"
module input_sync_parameters_tb_top;
	logic              clk_sys_i;
	logic              arst_n_i;
	logic [7:0]        addr_i;
	logic [31:0]       wdata_i;
	logic              wr_i;
	logic              rd_i;
	logic [31:0]       rdata_o;
	isp_pkg::isp_evt_s evt_i;
	isp_pkg::isp_evt_s fire;
	logic              has_outputs_i;
	logic              operational_i;
	logic              copy_done_i;
	logic              sample_o;
	logic              ready_o;
	logic              irq_o;
	logic [7:0]        copy_dly;
	int                bad_count;
	int                tests_run;

	isp_input_sync_params i_isp_input_sync_params (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.evt_i(evt_i), .has_outputs_i(has_outputs_i), .operational_i(operational_i),
		.copy_done_i(copy_done_i), .sample_o(sample_o), .ready_o(ready_o), .irq_o(irq_o));
	isp_master_model i_isp_master_model (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.fire_i(fire), .sample_i(sample_o), .copy_dly_i(copy_dly), .evt_o(evt_i),
		.copy_done_o(copy_done_i));

	// clock
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i    <= 1'b0;
	endtask

	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i   <= 1'b0;
		#1 chk(n, rdata_o, e);
	endtask

	task automatic rst(input logic outs);
		arst_n_i      <= 1'b0;
		has_outputs_i <= outs;
		repeat (12) @(posedge clk_sys_i);
		arst_n_i      <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
	endtask

	// request one event; returns at the edge the partner drives it
	task automatic fire_evt(input isp_pkg::isp_evt_s ev);
		@(posedge clk_sys_i);
		fire <= ev;
		@(posedge clk_sys_i);
		fire <= '0;
	endtask

	task automatic t_reset_values();
		rst(1'b1);
		rc("count", `ISP_IDX_COUNT, 32'h20);
		rc("mode", `ISP_IDX_MODE, 32'h22);
		rc("period", `ISP_IDX_PERIOD, 32'h000F4240);
		rc("shift", `ISP_IDX_SHIFT, 32'h0);
		rc("support", `ISP_IDX_SUPPORT, 32'h4017);
		rc("minper", `ISP_IDX_MINPER, 32'h000186A0);
		rc("copy", `ISP_IDX_COPY, 32'h0);
		rc("maxdly", `ISP_IDX_MAXDLY, 32'h0);
		rc("missed", `ISP_IDX_MISSED, 32'h0);
		rc("overrun", `ISP_IDX_OVERRUN, 32'h0);
		rc("unmapped", 8'h0A, 32'h0);
		wr(`ISP_IDX_MINPER, 32'h0);
		wr(`ISP_IDX_COUNT, 32'h5);
		rc("minper ro", `ISP_IDX_MINPER, 32'h000186A0);
		rc("count ro", `ISP_IDX_COUNT, 32'h20);
		wr(`ISP_IDX_MODE, 32'h1);
		rc("mode1 refused", `ISP_IDX_MODE, 32'h22);
		wr(`ISP_IDX_MODE, 32'h5);
		rc("mode5 refused", `ISP_IDX_MODE, 32'h22);
	endtask

	task automatic t_sm2_walk();
		rst(1'b1);
		copy_dly <= 8'h02;
		fire_evt(4'b1000);
		@(posedge clk_sys_i);
		#1 chk("sm2 sample", sample_o, 1'b1);
		repeat (4) @(posedge clk_sys_i);
		#1 chk("sm2 ready", ready_o, 1'b1);
	endtask

	task automatic t_modes();
		logic [3:0] trig [4];
		logic [15:0] code [4];
		trig = '{4'b0010, 4'b0001, 4'b1000, 4'b0100};
		code = '{16'h2, 16'h3, 16'h22, 16'h1};
		rst(1'b0);
		rc("support no out", `ISP_IDX_SUPPORT, 32'h4027);
		copy_dly <= 8'h01;
		for (int i = 0; i < 4; i++) begin
			wr(`ISP_IDX_MODE, {16'h0, code[i]});
			rc("mode set", `ISP_IDX_MODE, {16'h0, code[i]});
			fire_evt(trig[i]);
			@(posedge clk_sys_i);
			#1 chk("mode sample", sample_o, 1'b1);
			repeat (4) @(posedge clk_sys_i);
		end
		wr(`ISP_IDX_PERIOD, 32'd100);
		wr(`ISP_IDX_MODE, 32'h0);
		wait_sample("free run tick");
	endtask

	task automatic wait_sample(input string n);
		logic got;
		got = 1'b0;
		repeat (25) begin
			@(posedge clk_sys_i);
			#1 got = got | sample_o;
		end
		chk(n, got, 1'b1);
	endtask

	task automatic t_overrun_irq();
		rst(1'b1);
		operational_i <= 1'b1;
		copy_dly      <= 8'h00;
		fire_evt(4'b1000);
		repeat (3) @(posedge clk_sys_i);
		fire_evt(4'b1000);
		@(posedge clk_sys_i);
		#1 chk("no sample busy", sample_o, 1'b0);
		rc("overrun cnt", `ISP_IDX_OVERRUN, 32'h1);
		rc("irq stat", `ISP_IDX_IRQ_STAT, 32'h1);
		chk("irq masked", irq_o, 1'b0);
		wr(`ISP_IDX_IRQ_MASK, 32'h1);
		@(posedge clk_sys_i);
		#1 chk("irq high", irq_o, 1'b1);
		wr(`ISP_IDX_IRQ_STAT, 32'h1);
		@(posedge clk_sys_i);
		#1 chk("irq cleared", irq_o, 1'b0);
		rst(1'b1);
		copy_dly <= 8'h01;
		wr(`ISP_IDX_MODE, 32'h2);
		repeat (3) begin
			fire_evt(4'b1000);
			fire_evt(4'b0010);
			repeat (4) @(posedge clk_sys_i);
		end
		rc("missed none", `ISP_IDX_MISSED, 32'h0);
		fire_evt(4'b0010);
		repeat (4) @(posedge clk_sys_i);
		rc("missed one", `ISP_IDX_MISSED, 32'h1);
		rc("missed stat", `ISP_IDX_IRQ_STAT, 32'h2);
		copy_dly <= 8'h00;
		fire_evt(4'b0010);
		fire_evt(4'b0001);
		fire_evt(4'b0010);
		repeat (2) @(posedge clk_sys_i);
		rc("short cnt", `ISP_IDX_SHORT, 32'h1);
		rc("fault", `ISP_IDX_FAULT, 32'h1);
		rc("dc overrun", `ISP_IDX_OVERRUN, 32'h1);
	endtask

	task automatic t_measure();
		rst(1'b1);
		operational_i <= 1'b0;
		copy_dly      <= 8'h04;
		wr(`ISP_IDX_MODE, 32'h3);
		wr(`ISP_IDX_CMD, 32'h1);
		rc("cmd", `ISP_IDX_CMD, 32'h1);
		fire_evt(4'b0010);
		repeat (3) @(posedge clk_sys_i);
		fire_evt(4'b0001);
		repeat (8) @(posedge clk_sys_i);
		rc("shift", `ISP_IDX_SHIFT, 32'h32);
		rc("copy", `ISP_IDX_COPY, 32'h3C);
		rc("maxdly sync1", `ISP_IDX_MAXDLY, 32'h0);
		wr(`ISP_IDX_CMD, 32'h0);
		wr(`ISP_IDX_CMD, 32'h1);
		rc("shift reset", `ISP_IDX_SHIFT, 32'h0);
		rc("copy reset", `ISP_IDX_COPY, 32'h0);
	endtask

	task automatic results();
		if (bad_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// watchdog
	initial begin
		#200us;
		bad_count++;
		results();
	end

	// main sequence
	initial begin
		bad_count = 0;
		tests_run = 0;
		arst_n_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		fire = '0;
		has_outputs_i = 1'b1;
		operational_i = 1'b0;
		copy_dly = 8'h01;
		t_reset_values();
		t_sm2_walk();
		t_modes();
		t_overrun_irq();
		t_measure();
		results();
	end
endmodule // input_sync_parameters_tb_top
